// File: hw/pmbus_target_pec_group_ara.sv
// Notes on behaviour
// R1 - target on link up to 1 MHz
// R2 - byte, word, block transfers, checksum optional
// R3 - checksum byte last, just before stop
// R4 - device sends checksum on reads
// R5 - device checks checksum on writes
// R6 - mismatch: ignore command, drop all bytes
// R7 - mismatch: set summary and checksum flags
// R8 - mismatch: pull alert line low
// R9 - enabled faults pull alert line low
// R10 - host: group sequence with repeated starts
// R11 - group command runs only at stop
// R12 - host: each target once per group
// R13 - host: no reading commands in group
// R14 - group checksum covers own sub-packet only
// R15 - checksum frozen at repeated start
// R16 - alert response read returns own address
// R17 - lowest address wins, losers keep alerting
// R18 - winner masks present faults, status kept
// R19 - mask cleared only by clear faults
// R20 - host: clear faults when servicing alert
// R21 - respond to own or broadcast address (code answers only its own address, and the ara address while alerting)
// R22 - crc-8 poly 07, zero start
// R23 - scl low too long: back to idle
`default_nettype none
module pmbus_target_pec_group_ara #(
  parameter int N_FAULT        = 8,
  parameter int DEPTH          = 4,
  parameter int TIMEOUT_CYCLES = pmbus_target_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // two-wire link
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe,
  // open-drain alert
  input  wire logic               alert_line_n_i,
  output logic                    alert_line_n_o,
  output logic                    alert_line_n_oe,
  // device side
  input  wire logic [N_FAULT-1:0] fault_in,
  output logic                    exec_pulse
);

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int NF = N_FAULT + 1;

  typedef struct packed {
    logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q, aln_s1, aln_s2;
    pmbus_target_pkg::link_state_t state;
    logic [3:0]            bitcnt;
    logic [7:0]            shift;
    logic                  first, rd, ara, lost, acked, busy, wr_pend;
    logic [7:0]            nbytes, crc, tidx;
    logic [7:0]            stage_cmd;
    logic [DEPTH-1:0][7:0] stage;
    logic [6:0]            own_addr;
    logic                  pec_en;
    logic [NF-1:0]         alert_en, mask;
    logic                  cmd_ready, bad_chk, comm_fault, tmo_flag;
    logic [7:0]            rx_cmd, rx_cnt, tx_len;
    logic [DEPTH-1:0][7:0] rx, tx;
    logic [TW-1:0]         tmo_cnt;
    logic                  sda_o, sda_oe, aln_o, aln_oe, exec;
    logic                  pready, pslverr;
    logic [31:0]           prdata;
  } state_t;

  state_t st;
  state_t next_st;

  // ==========================================================
  // link events from synchronised pins
  logic          scl_rise, scl_fall, start_evt, stop_evt, tmo_hit;
  logic          pec_ok, commit_ok, fail_evt, clr_evt, ara_win, access;
  logic [NF-1:0] faults;
  logic [7:0]    cand, crc_seed, crc_data, crc_next;

  assign scl_rise  = st.scl_s2 & ~st.scl_q; // R1
  assign scl_fall  = ~st.scl_s2 & st.scl_q;
  assign start_evt = st.scl_s2 & st.scl_q & st.sda_q & ~st.sda_s2;
  assign stop_evt  = st.scl_s2 & st.scl_q & ~st.sda_q & st.sda_s2;
  assign tmo_hit   = (st.tmo_cnt == TW'(TIMEOUT_CYCLES));
  assign pec_ok    = ~st.pec_en | ((st.nbytes >= 8'h02) & (st.crc == 8'h00)); // R3 R5
  assign commit_ok = ~tmo_hit & stop_evt & st.wr_pend & (st.nbytes != 8'h00) & pec_ok;
  assign fail_evt  = ~tmo_hit & stop_evt & st.wr_pend & (st.nbytes != 8'h00) & ~pec_ok;
  assign clr_evt   = commit_ok & (st.stage_cmd == pmbus_target_pkg::CMD_CLEAR_FAULTS);
  assign ara_win   = ~tmo_hit & ~start_evt & ~stop_evt & (st.state == pmbus_target_pkg::ST_SEND)
                   & scl_fall & (st.bitcnt == 4'h8) & st.ara & ~st.lost; // R17
  assign faults    = {st.comm_fault, fault_in};
  assign access    = psel & penable & ~st.pready;

  // ==========================================================
  // next byte to transmit
  always_comb begin
    if (st.ara) begin
      cand = (st.tidx == 8'h00) ? {st.own_addr, 1'b0} : pmbus_target_pkg::IDLE_BYTE; // R16
    end else if ((st.tidx < st.tx_len) && (st.tidx < 8'(DEPTH))) begin
      cand = st.tx[st.tidx[IW-1:0]];
    end else if (st.tidx == st.tx_len) begin
      cand = st.crc; // R4
    end else begin
      cand = pmbus_target_pkg::IDLE_BYTE;
    end
  end

  assign crc_data = (st.state == pmbus_target_pkg::ST_RECV) ? st.shift : cand;
  assign crc_seed = ((st.state == pmbus_target_pkg::ST_RECV) & st.first & ~st.shift[0])
                  ? 8'h00 : st.crc; // R14

  crc8_step u_crc (
    .crc_in  (crc_seed),
    .data    (crc_data),
    .crc_out (crc_next)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic       hit;
    logic       do_load;
    logic [7:0] didx;
    next_st = st;
    hit     = 1'b0;
    do_load = 1'b0;
    didx    = st.nbytes - 8'h01;
    next_st.scl_s1 = scl_i;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_q  = st.scl_s2;
    next_st.sda_s1 = sda_i;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_q  = st.sda_s2;
    next_st.aln_s1 = alert_line_n_i;
    next_st.aln_s2 = st.aln_s1;
    next_st.exec   = 1'b0;
    next_st.sda_o  = 1'b0;
    next_st.aln_o  = 1'b0;

    // apb slave, one wait state
    next_st.pready  = access;
    next_st.pslverr = 1'b0;
    if (access) begin
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        pmbus_target_pkg::OFS_CTRL: begin
          if (pwrite) begin
            next_st.own_addr = pwdata[6:0];
            next_st.pec_en   = pwdata[pmbus_target_pkg::CTRL_PEC_BIT];
          end
          next_st.prdata[6:0] = st.own_addr;
          next_st.prdata[pmbus_target_pkg::CTRL_PEC_BIT] = st.pec_en;
        end
        pmbus_target_pkg::OFS_ALERT_EN: begin
          if (pwrite) begin
            next_st.alert_en = pwdata[NF-1:0]; // R9
          end
          next_st.prdata[NF-1:0] = st.alert_en;
        end
        pmbus_target_pkg::OFS_STATUS: begin
          if (pwrite) begin
            if (pwdata[pmbus_target_pkg::STAT_CMD_READY])  next_st.cmd_ready  = 1'b0;
            if (pwdata[pmbus_target_pkg::STAT_BAD_CHKSUM]) next_st.bad_chk    = 1'b0;
            if (pwdata[pmbus_target_pkg::STAT_COMM_FAULT]) next_st.comm_fault = 1'b0;
            if (pwdata[pmbus_target_pkg::STAT_TIMEOUT])    next_st.tmo_flag   = 1'b0;
          end
          next_st.prdata[pmbus_target_pkg::STAT_CMD_READY]  = st.cmd_ready;
          next_st.prdata[pmbus_target_pkg::STAT_BAD_CHKSUM] = st.bad_chk;
          next_st.prdata[pmbus_target_pkg::STAT_COMM_FAULT] = st.comm_fault;
          next_st.prdata[pmbus_target_pkg::STAT_ALERT]      = st.aln_oe;
          next_st.prdata[pmbus_target_pkg::STAT_TIMEOUT]    = st.tmo_flag;
          next_st.prdata[pmbus_target_pkg::STAT_LINE_LOW]   = ~st.aln_s2;
        end
        pmbus_target_pkg::OFS_MASK: next_st.prdata[NF-1:0] = st.mask;
        pmbus_target_pkg::OFS_RX_CMD: begin
          next_st.prdata[7:0] = st.rx_cmd;
          next_st.prdata[pmbus_target_pkg::RXCMD_CNT_LSB +: 8] = st.rx_cnt;
        end
        pmbus_target_pkg::OFS_TX_LEN: begin
          if (pwrite) begin
            next_st.tx_len = pwdata[7:0];
          end
          next_st.prdata[7:0] = st.tx_len;
        end
        default: begin
          for (int i = 0; i < DEPTH; i++) begin
            if (paddr == pmbus_target_pkg::OFS_RX_BASE + 12'(4 * i)) begin
              hit = 1'b1;
              next_st.prdata[7:0] = st.rx[i];
            end
            if (paddr == pmbus_target_pkg::OFS_TX_BASE + 12'(4 * i)) begin
              hit = 1'b1;
              if (pwrite) begin
                next_st.tx[i] = pwdata[7:0];
              end
              next_st.prdata[7:0] = st.tx[i];
            end
          end
          next_st.pslverr = ~hit;
        end
      endcase
    end

    // bus timeout counter
    if (st.scl_s2) begin
      next_st.tmo_cnt = '0;
    end else if (!tmo_hit) begin
      next_st.tmo_cnt = st.tmo_cnt + TW'(1);
    end

    // link engine
    if (tmo_hit) begin
      next_st.state    = pmbus_target_pkg::ST_IDLE; // R23
      next_st.sda_oe   = 1'b0;
      next_st.busy     = 1'b0;
      next_st.wr_pend  = 1'b0;
      next_st.tmo_flag = 1'b1;
    end else if (start_evt) begin
      if (!st.busy) begin
        next_st.crc     = 8'h00;
        next_st.wr_pend = 1'b0;
      end
      next_st.busy   = 1'b1; // R15
      next_st.state  = pmbus_target_pkg::ST_RECV;
      next_st.bitcnt = 4'h0;
      next_st.first  = 1'b1;
      next_st.sda_oe = 1'b0;
      next_st.ara    = 1'b0;
      next_st.lost   = 1'b0;
    end else if (stop_evt) begin
      if (commit_ok) begin
        next_st.rx_cmd    = st.stage_cmd; // R11
        next_st.rx        = st.stage;
        next_st.rx_cnt    = st.nbytes - (st.pec_en ? 8'h02 : 8'h01);
        next_st.cmd_ready = 1'b1;
        next_st.exec      = 1'b1;
      end
      if (fail_evt) begin
        next_st.bad_chk    = 1'b1; // R6 R7
        next_st.comm_fault = 1'b1;
      end
      if (clr_evt) begin
        next_st.mask       = '0; // R19
        next_st.bad_chk    = 1'b0;
        next_st.comm_fault = 1'b0;
      end
      next_st.busy    = 1'b0;
      next_st.wr_pend = 1'b0;
      next_st.state   = pmbus_target_pkg::ST_IDLE;
      next_st.sda_oe  = 1'b0;
    end else begin
      case (st.state)
        pmbus_target_pkg::ST_RECV: begin
          if (scl_rise) begin
            next_st.shift  = {st.shift[6:0], st.sda_s2};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.first = 1'b0;
            if (st.first) begin
              if (st.shift[7:1] == st.own_addr) begin
                next_st.state   = pmbus_target_pkg::ST_ACK; // R21
                next_st.sda_oe  = 1'b1;
                next_st.crc     = crc_next;
                next_st.rd      = st.shift[0];
                next_st.tidx    = 8'h00;
                next_st.wr_pend = ~st.shift[0];
                next_st.nbytes  = 8'h00;
              end else if (st.shift == {pmbus_target_pkg::ARA_ADDR, 1'b1} && st.aln_oe) begin
                next_st.state  = pmbus_target_pkg::ST_ACK; // R16
                next_st.sda_oe = 1'b1;
                next_st.rd     = 1'b1;
                next_st.ara    = 1'b1;
                next_st.tidx   = 8'h00;
              end else begin
                next_st.state = pmbus_target_pkg::ST_IDLE;
              end
            end else begin
              if (st.nbytes == 8'h00) begin
                next_st.stage_cmd = st.shift;
              end else if (didx < 8'(DEPTH)) begin
                next_st.stage[didx[IW-1:0]] = st.shift; // R2
              end
              next_st.nbytes = st.nbytes + 8'h01;
              next_st.crc    = crc_next; // R5
              next_st.state  = pmbus_target_pkg::ST_ACK;
              next_st.sda_oe = 1'b1;
            end
          end
        end
        pmbus_target_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (st.rd) begin
              do_load = 1'b1;
            end else begin
              next_st.state  = pmbus_target_pkg::ST_RECV;
              next_st.bitcnt = 4'h0;
              next_st.sda_oe = 1'b0;
            end
          end
        end
        pmbus_target_pkg::ST_SEND: begin
          if (scl_rise) begin
            if (st.ara && st.shift[7] && !st.sda_s2) begin
              next_st.lost = 1'b1; // R17
            end
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (st.bitcnt == 4'h8) begin
              next_st.state  = pmbus_target_pkg::ST_HACK;
              next_st.sda_oe = 1'b0;
              if (ara_win) begin
                next_st.mask = st.mask | faults; // R18
              end
            end else begin
              next_st.shift  = {st.shift[6:0], 1'b1};
              next_st.sda_oe = ~st.shift[6] & ~st.lost;
            end
          end
        end
        pmbus_target_pkg::ST_HACK: begin
          if (scl_rise) begin
            next_st.acked = ~st.sda_s2;
          end else if (scl_fall) begin
            if (st.acked) begin
              do_load = 1'b1;
            end else begin
              next_st.state = pmbus_target_pkg::ST_IDLE;
            end
          end
        end
        default: next_st.state = pmbus_target_pkg::ST_IDLE;
      endcase
    end
    if (do_load) begin
      next_st.shift  = cand;
      next_st.crc    = crc_next; // R4
      next_st.tidx   = st.tidx + 8'h01;
      next_st.state  = pmbus_target_pkg::ST_SEND;
      next_st.bitcnt = 4'h0;
      next_st.sda_oe = ~cand[7];
      next_st.lost   = 1'b0;
    end

    next_st.aln_oe = |(faults & st.alert_en & ~st.mask); // R8 R9
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.scl_s1   <= 1'b1;
      st.scl_s2   <= 1'b1;
      st.scl_q    <= 1'b1;
      st.sda_s1   <= 1'b1;
      st.sda_s2   <= 1'b1;
      st.sda_q    <= 1'b1;
      st.aln_s1   <= 1'b1;
      st.aln_s2   <= 1'b1;
      st.state    <= pmbus_target_pkg::ST_IDLE;
      st.own_addr <= pmbus_target_pkg::OWN_ADDR_RST;
      st.pec_en   <= pmbus_target_pkg::PEC_EN_RST;
      st.alert_en <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata          = st.prdata;
  assign pready          = st.pready;
  assign pslverr         = st.pslverr;
  assign sda_o           = st.sda_o;
  assign sda_oe          = st.sda_oe;
  assign alert_line_n_o  = st.aln_o;
  assign alert_line_n_oe = st.aln_oe;
  assign exec_pulse      = st.exec;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_timeout_idle;
    tmo_hit |=> (st.state == pmbus_target_pkg::ST_IDLE) && !sda_oe && !st.busy;
  endproperty
  a_timeout_idle: assert property (p_timeout_idle) else $error("timeout did not idle"); // R23

  property p_fail_flags;
    fail_evt |=> st.bad_chk && st.comm_fault && !exec_pulse;
  endproperty
  a_fail_flags: assert property (p_fail_flags) else $error("checksum flags not set"); // R7

  property p_fail_discard;
    fail_evt && !access |=> $stable(st.rx_cmd) && $stable(st.rx_cnt) && $stable(st.rx);
  endproperty
  a_fail_discard: assert property (p_fail_discard) else $error("bad packet stored"); // R6

  property p_fail_alert;
    fail_evt && st.alert_en[N_FAULT] && !st.mask[N_FAULT] && !access |=> ##1 alert_line_n_oe;
  endproperty
  a_fail_alert: assert property (p_fail_alert) else $error("alert not raised"); // R8

  property p_mask_hold;
    !clr_evt |=> (st.mask & $past(st.mask)) == $past(st.mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask cleared early"); // R19

  property p_ara_mask;
    ara_win |=> (st.mask & $past(faults)) == $past(faults);
  endproperty
  a_ara_mask: assert property (p_ara_mask) else $error("faults not masked"); // R18

  property p_restart_freeze;
    start_evt && st.busy && !tmo_hit |=> st.crc == $past(st.crc);
  endproperty
  a_restart_freeze: assert property (p_restart_freeze) else $error("crc moved"); // R15

  property p_exec_at_stop;
    $rose(st.cmd_ready) |-> $past(stop_evt) && $past(st.wr_pend);
  endproperty
  a_exec_at_stop: assert property (p_exec_at_stop) else $error("run before stop"); // R11

  property p_ara_lost;
    (st.state == pmbus_target_pkg::ST_SEND) && st.ara && st.lost |-> !ara_win && !sda_oe;
  endproperty
  a_ara_lost: assert property (p_ara_lost) else $error("lost ara masked"); // R17

  property p_alert_enable;
    alert_line_n_oe |-> $past(|(faults & st.alert_en & ~st.mask));
  endproperty
  a_alert_enable: assert property (p_alert_enable) else $error("alert without fault"); // R9

  c_commit:  cover property (commit_ok);
  c_fail:    cover property (fail_evt);
  c_ara_win: cover property (ara_win);
  c_timeout: cover property (tmo_hit);

endmodule : pmbus_target_pec_group_ara
`default_nettype wire

// File: hw/pmbus_target_pkg.sv
`default_nettype none
package pmbus_target_pkg;

  // ==========================================================
  // apb register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_ALERT_EN = 12'h004;
  localparam logic [11:0] OFS_STATUS   = 12'h008;
  localparam logic [11:0] OFS_MASK     = 12'h00C;
  localparam logic [11:0] OFS_RX_CMD   = 12'h010;
  localparam logic [11:0] OFS_TX_LEN   = 12'h014;
  localparam logic [11:0] OFS_RX_BASE  = 12'h040;
  localparam logic [11:0] OFS_TX_BASE  = 12'h080;

  // ==========================================================
  // field positions
  localparam int CTRL_PEC_BIT     = 8;
  localparam int STAT_CMD_READY   = 0;
  localparam int STAT_BAD_CHKSUM  = 1;
  localparam int STAT_COMM_FAULT  = 2;
  localparam int STAT_ALERT       = 3;
  localparam int STAT_TIMEOUT     = 4;
  localparam int STAT_LINE_LOW    = 5;
  localparam int RXCMD_CNT_LSB    = 8;

  // ==========================================================
  // reset values and link constants
  localparam logic [6:0] OWN_ADDR_RST     = 7'h40;
  localparam logic       PEC_EN_RST       = 1'b0;
  localparam logic [6:0] ARA_ADDR         = 7'h0C;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CRC_POLY         = 8'h07;
  localparam logic [7:0] IDLE_BYTE        = 8'hFF;

  // ==========================================================
  // timing
  localparam longint CLK_FREQ_HZ    = 200_000_000;
  localparam longint TIMEOUT_MIN_MS = 25;
  localparam int     TIMEOUT_CYCLES =
    int'((TIMEOUT_MIN_MS * CLK_FREQ_HZ + 64'd999) / 64'd1000);

  // ==========================================================
  // link state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b010,
    ST_SEND = 3'b011,
    ST_HACK = 3'b100
  } link_state_t;

endpackage : pmbus_target_pkg
`default_nettype wire

// File: hw/crc8_step.sv
`default_nettype none
module crc8_step (
  // running value and next byte
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data,
  // updated value
  output logic      [7:0] crc_out
);

  // ==========================================================
  // msb-first crc-8, one byte per call
  always_comb begin
    crc_out = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      if (crc_out[7]) begin
        crc_out = {crc_out[6:0], 1'b0} ^ pmbus_target_pkg::CRC_POLY; // R22
      end else begin
        crc_out = {crc_out[6:0], 1'b0};
      end
    end
  end

endmodule : crc8_step
`default_nettype wire

// File: verification/pmbus_host_model.sv
`default_nettype none
module pmbus_host_model (
  // link wires
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // ==========
  // start or repeated start, then stop
  task automatic start_c();
    #1 sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
    #39;
  endtask : start_c

  task automatic stop_c();
    #1 sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #39;
  endtask : stop_c

  // ==========
  // one bit, 160 ns, data moved well clear of the clock fall
  task automatic bit_c(input logic b, output logic s);
    #10 sda_low = ~b;
    #30 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
    #40;
  endtask : bit_c

  // msb first, ninth bit is the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], s);
    end
    bit_c(1'b1, s);
    ack = ~s;
  endtask : wbyte

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, d[i]);
    end
    bit_c(nack, s);
  endtask : rbyte
endmodule : pmbus_host_model
`default_nettype wire

// File: verification/pmbus_target_pec_group_ara_tb_top.sv
`default_nettype none
module pmbus_target_pec_group_ara_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bq_t[$];
  localparam int TOC = 2000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ack;
  logic        scl, host_low, sda_o, sda_oe, al_o, al_oe, exec_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  fault_in, b, pb, dat;
  int          failures, compares, execs, e0, seed, n;
  wire logic   sda_w = ~(sda_oe | host_low);

  pmbus_target_pec_group_ara #(.TIMEOUT_CYCLES(TOC)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .alert_line_n_i(~al_oe),
    .alert_line_n_o(al_o), .alert_line_n_oe(al_oe), .fault_in(fault_in),
    .exec_pulse(exec_pulse));
  pmbus_host_model host_u (.scl(scl), .sda_low(host_low), .sda(sda_w));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (exec_pulse === 1'b1) execs++;
  initial begin
    #300_000;
    failures++;
    finish_test();
  end

  // ==========
  // helpers
  function automatic logic [7:0] crc8(input bq_t q);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) begin
      c = c ^ q[i];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8

  function automatic bq_t pec(input bq_t q);
    return {q, crc8(q)};
  endfunction : pec

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic finish_test();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      finish_test();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rchk

  task automatic send(input bq_t s, input logic ea);
    foreach (s[i]) begin
      host_u.wbyte(s[i], ack);
      chk("ack", ea, ack);
    end
  endtask : send

  task automatic settle();
    repeat (20) @(posedge pclk);
  endtask : settle

  // ==========
  // main sequence
  initial begin
    seed = 24;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fault_in = 8'h00;
    presetn  = 1'b0;
    failures = 0;
    compares = 0;
    execs    = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", pmbus_target_pkg::OFS_CTRL, 32'h0000_0040);
    rchk("alert_en", pmbus_target_pkg::OFS_ALERT_EN, 32'h0000_01FF);
    rchk("status", pmbus_target_pkg::OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("pslverr", 1'b1, err);
    dat = 8'($random(seed));
    apb(1'b1, pmbus_target_pkg::OFS_TX_BASE, {24'h00_0000, dat});
    apb(1'b1, pmbus_target_pkg::OFS_TX_LEN, 32'h0000_0001);
    host_u.start_c();
    send({8'h80, 8'h30}, 1'b1);
    host_u.start_c();
    send({8'h81}, 1'b1);
    host_u.rbyte(1'b0, b);
    host_u.rbyte(1'b1, pb);
    host_u.stop_c();
    chk("rd_byte", dat, b);
    chk("rd_pec", crc8({8'h80, 8'h30, 8'h81, dat}), pb);
    // group command, second sub-packet for another target
    apb(1'b1, pmbus_target_pkg::OFS_CTRL, 32'h0000_0140);
    dat = 8'($random(seed));
    e0  = execs;
    host_u.start_c();
    send(pec({8'h80, 8'h21, dat}), 1'b1);
    host_u.start_c();
    send(pec({8'h82, 8'h55}), 1'b0);
    chk("early_exec", e0, execs);
    host_u.stop_c();
    settle();
    chk("exec", e0 + 1, execs);
    rchk("rx_cmd", pmbus_target_pkg::OFS_RX_CMD, 32'h0000_0121);
    rchk("rx_data", pmbus_target_pkg::OFS_RX_BASE, {24'h00_0000, dat});
    rchk("status_ok", pmbus_target_pkg::OFS_STATUS, 32'h0000_0001);
    // corrupted checksum
    apb(1'b1, pmbus_target_pkg::OFS_STATUS, 32'h0000_001F);
    e0 = execs;
    host_u.start_c();
    send({8'h80, 8'h22, dat, ~crc8({8'h80, 8'h22, dat})}, 1'b1);
    host_u.stop_c();
    settle();
    chk("exec_bad", e0, execs);
    rchk("rx_cmd_bad", pmbus_target_pkg::OFS_RX_CMD, 32'h0000_0121);
    rchk("status_bad", pmbus_target_pkg::OFS_STATUS, 32'h0000_002E);
    chk("alert_bad", 1'b1, al_oe);
    chk("al_o", 1'b0, al_o);
    chk("sda_o", 1'b0, sda_o);
    // alert response lost to a lower address
    host_u.start_c();
    send({8'h19}, 1'b1);
    host_u.wbyte(8'h40, ack);
    host_u.stop_c();
    settle();
    chk("ara_lose", 1'b1, al_oe);
    rchk("mask_lose", pmbus_target_pkg::OFS_MASK, 32'h0000_0000);
    // alert response read with a fault present
    fault_in <= 8'h01 << dat[2:0];
    host_u.start_c();
    send({8'h19}, 1'b1);
    host_u.rbyte(1'b1, b);
    host_u.stop_c();
    chk("ara", 32'h0000_0080, b);
    settle();
    chk("alert_masked", 1'b0, al_oe);
    rchk("mask", pmbus_target_pkg::OFS_MASK, 32'h0000_0100 | fault_in);
    rchk("status_kept", pmbus_target_pkg::OFS_STATUS, 32'h0000_0006);
    host_u.start_c();
    send(pec({8'h80, 8'h03}), 1'b1);
    host_u.stop_c();
    settle();
    rchk("mask_clr", pmbus_target_pkg::OFS_MASK, 32'h0000_0000);
    chk("alert_refault", 1'b1, al_oe);
    fault_in <= 8'h00;
    settle();
    chk("alert_idle", 1'b0, al_oe);
    // foreign address, then a stuck clock
    e0 = execs;
    host_u.start_c();
    send(pec({8'h82, 8'h01, dat}), 1'b0);
    host_u.stop_c();
    settle();
    chk("exec_other", e0, execs);
    host_u.start_c();
    b = 8'h80;
    for (int i = 7; i >= 0; i--) host_u.bit_c(b[i], ack);
    repeat (4) @(posedge pclk);
    chk("sda_ack", 1'b1, sda_oe);
    repeat (TOC + 100) @(posedge pclk);
    rchk("timeout", pmbus_target_pkg::OFS_STATUS, 32'h0000_0011);
    chk("sda_free", 1'b0, sda_oe);
    host_u.stop_c();
    settle();
    chk("exec_tmo", e0, execs);
    finish_test();
  end
endmodule : pmbus_target_pec_group_ara_tb_top
`default_nettype wire
